// ### bench/sacc_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sacc_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  shared_port_pins_out,
  input wire logic [7:0]  shared_port_pins_oe,
  input wire logic [7:0]  amux_pin_sel,
  input wire logic        amux_ref_high,
  input wire logic        amux_ref_low,
  input wire logic        adc_power,
  input wire logic        sample_hold,
  input wire logic        conv_irq
);
  wire acc    = psel && penable && pready;
  wire ctrl_wr = acc && pwrite && (paddr == sacc_pkg::OFF_CTRL);
  wire res_rd = acc && !pwrite &&
                (paddr == sacc_pkg::OFF_RES_HI || paddr == sacc_pkg::OFF_RES_LO);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pin_onehot: assert property ($onehot0(amux_pin_sel))
    else $error("more than one pin routed");
  chk_sel_undriven: assert property ((shared_port_pins_oe & amux_pin_sel) == 8'h00)
    else $error("selected pin driven");
  chk_sel_out_zero: assert property ((shared_port_pins_out & amux_pin_sel) == 8'h00)
    else $error("selected pin output not zero");
  chk_off_no_route: assert property (!adc_power |-> amux_pin_sel == 8'h00
    && !amux_ref_high && !amux_ref_low && !sample_hold)
    else $error("routing while powered off");
  chk_ref_exclusive: assert property (amux_ref_high || amux_ref_low |->
    !(amux_ref_high && amux_ref_low) && amux_pin_sel == 8'h00)
    else $error("references not exclusive");
  chk_start_samples: assert property (ctrl_wr && pwdata[4:0] != sacc_pkg::CH_OFF |->
    ##[1:20] sample_hold)
    else $error("no sampling after start");
  chk_irq_wr_clear: assert property (ctrl_wr |=> !conv_irq)
    else $error("irq not cleared by control write");
  chk_irq_rd_clear: assert property (res_rd |=> !conv_irq)
    else $error("irq not cleared by result read");
  chk_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one access cycle");
  chk_err_unmapped: assert property (pready && paddr > sacc_pkg::OFF_PORT_DIR |-> pslverr)
    else $error("unmapped access not refused");
  chk_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  cover property ($rose(conv_irq));
  cover property (pslverr);
  cover property ($fell(adc_power));
  cover property (res_rd);
endmodule
bind sacc_top sacc_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .shared_port_pins_out, .shared_port_pins_oe,
  .amux_pin_sel, .amux_ref_high, .amux_ref_low, .adc_power, .sample_hold, .conv_irq);
`default_nettype wire

// ### bench/test_sar_adc_conversion_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_conversion_control;
  logic        pclk = 1'b0;
  logic        osc = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        cmp_above = 1'b0;
  logic [7:0]  pins_in = 8'h00;
  logic [10:0] vin = 11'h000;
  logic [31:0] prdata, rd;
  logic [7:0]  pins_out, pins_oe, pin_sel, s, d, dirv;
  logic [7:0]  pd = 8'h00;
  logic        pready, pslverr, ref_hi, ref_lo, adc_power, sample_hold, conv_irq, err;
  logic [9:0]  dac_code;
  int          fail_count = 0;
  int          tests_run = 0;
  int          seed = 32'h0000_3d76;
  int          cyc = 0;
  int          n;

  always #12.5 pclk = ~pclk;
  // Oscillator deliberately unrelated to the bus clock
  always #45 osc = ~osc;
  always @(posedge pclk) cyc <= cyc + 1;
  // Analog input sits half a code above vin, so a trial wins when vin >= code
  always @(posedge pclk) cmp_above <= (vin >= {1'b0, dac_code});

  sacc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_clock(osc), .cmp_above(cmp_above),
    .shared_port_pins_in(pins_in), .shared_port_pins_out(pins_out),
    .shared_port_pins_oe(pins_oe), .amux_pin_sel(pin_sel), .amux_ref_high(ref_hi),
    .amux_ref_low(ref_lo), .adc_power(adc_power), .sample_hold(sample_hold),
    .dac_code(dac_code), .conv_irq(conv_irq));

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic give_up(input string what);
    check(what, 1, 0);
    close_out;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
      give_up("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done;
    int k;
    for (k = 0; k < 150; k++)
    begin
      apb(1'b0, sacc_pkg::OFF_CTRL, 0);
      if (rd[7] === 1'b1)
        break;
    end
    if (k == 150)
      give_up("done flag");
  endtask

  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
    case (m)
      sacc_pkg::MODE_LEFT:   fmt = {r, 6'h00};
      sacc_pkg::MODE_RIGHT:  fmt = {6'h00, r};
      sacc_pkg::MODE_SIGNED: fmt = {~r[9], r[8:0], 6'h00};
      default:               fmt = {8'h00, r[9:2]};
    endcase
  endfunction

  task automatic read_res(input logic [15:0] e);
    apb(1'b0, sacc_pkg::OFF_RES_HI, 0);
    check("result high", 32'(e[15:8]), rd);
    apb(1'b0, sacc_pkg::OFF_RES_LO, 0);
    check("result low", 32'(e[7:0]), rd);
  endtask

  // First start is cut short by a second one; timing runs from the second
  task automatic conv(input logic [1:0] m, input logic [4:0] ch, input logic [10:0] v,
                      input logic [2:0] dv, input logic src, input int lo_c, input int hi_c);
    int t0;
    vin <= v;
    apb(1'b1, sacc_pkg::OFF_CLK, {24'h00_0000, dv, src, m, 2'h0});
    apb(1'b1, sacc_pkg::OFF_CTRL, {27'h000_0000, ch});
    repeat (30) @(posedge pclk);
    apb(1'b1, sacc_pkg::OFF_CTRL, {27'h000_0000, ch});
    t0 = cyc;
    wait_done;
    check("conversion time", 1, 32'(cyc - t0 >= lo_c && cyc - t0 <= hi_c));
    read_res(fmt(m, (v > 11'h3FF) ? 10'h3FF : v[9:0]));
  endtask

  task automatic rst_check;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sacc_pkg::OFF_CTRL, 0);
    check("control after reset", 0, rd);
    apb(1'b0, sacc_pkg::OFF_CLK, 0);
    check("clock after reset", 0, rd);
    read_res(16'h0000);
  endtask

  initial
  begin
    rst_check;
    apb(1'b0, 8'h18, 0);
    check("unmapped error", 1, 32'(err));
    check("unmapped data", 0, rd);
    for (n = 0; n < 4; n++)
      conv(n[1:0], {$random(seed)} % 8, {$random(seed)} % 1024, sacc_pkg::DIV_4, 1'b0,
           62, 80);
    conv(sacc_pkg::MODE_RIGHT, 5'h03, 11'h7FF, sacc_pkg::DIV_4, 1'b0, 62, 80);
    conv(sacc_pkg::MODE_SIGNED, 5'h00, 11'h000, sacc_pkg::DIV_4, 1'b0, 62, 80);
    conv(sacc_pkg::MODE_RIGHT, 5'h05, {$random(seed)} % 1024, sacc_pkg::DIV_2, 1'b1,
         110, 135);
    // Slowest prescaler codes, so every divide ratio except divide-by-1 is exercised
    conv(sacc_pkg::MODE_LEFT, 5'h07, {$random(seed)} % 1024, sacc_pkg::DIV_8, 1'b0,
         126, 150);
    conv(sacc_pkg::MODE_TRUNC, 5'h04, {$random(seed)} % 1024, 3'h5, 1'b0,
         254, 290);
    for (n = 0; n < 8; n++)
    begin
      s = 8'h01 << n;
      d = $random(seed);
      dirv = $random(seed);
      pins_in <= $random(seed);
      apb(1'b1, sacc_pkg::OFF_CTRL, n);
      apb(1'b1, sacc_pkg::OFF_PORT_DIR, 32'(dirv));
      apb(1'b1, sacc_pkg::OFF_PORT_DAT, 32'(d));
      repeat (4) @(posedge pclk);
      check("pin select", 32'(s), 32'(pin_sel));
      check("pin drive", 32'(dirv & ~s), 32'(pins_oe));
      check("pin out", 32'(d & ~s), 32'(pins_out));
      apb(1'b0, sacc_pkg::OFF_PORT_DAT, 0);
      check("port read", 32'(((dirv & d) | (~dirv & pins_in)) & ~s), rd);
      // Selected bit must keep what it held before this channel was chosen
      pd = (dirv & ~s) | (pd & s);
      apb(1'b0, sacc_pkg::OFF_PORT_DIR, 0);
      check("direction kept", 32'(pd), rd);
    end
    for (n = 29; n < 32; n++)
    begin
      apb(1'b1, sacc_pkg::OFF_CTRL, n);
      repeat (3) @(posedge pclk);
      check("reference route", {29'h0, n == 29, n == 30, n != 31},
            {29'h0, ref_hi, ref_lo, adc_power});
    end
    vin <= 11'h155;
    apb(1'b1, sacc_pkg::OFF_CLK, 32'h0000_0040);
    apb(1'b1, sacc_pkg::OFF_CTRL, 32'h0000_0001);
    wait_done;
    apb(1'b0, sacc_pkg::OFF_RES_HI, 0);
    vin <= 11'h2AA;
    apb(1'b1, sacc_pkg::OFF_CTRL, 32'h0000_0001);
    wait_done;
    apb(1'b0, sacc_pkg::OFF_RES_LO, 0);
    check("locked low", 32'h0000_0040, rd);
    apb(1'b0, sacc_pkg::OFF_RES_HI, 0);
    check("discarded high", 32'h0000_0055, rd);
    apb(1'b0, sacc_pkg::OFF_RES_LO, 0);
    vin <= 11'h0C3;
    apb(1'b1, sacc_pkg::OFF_CLK, 32'h0000_0044);
    apb(1'b1, sacc_pkg::OFF_CTRL, 32'h0000_0022);
    wait_done;
    repeat (200) @(posedge pclk);
    apb(1'b0, sacc_pkg::OFF_CTRL, 0);
    check("done holds", 1, 32'(rd[7]));
    vin <= 11'h31E;
    repeat (200) @(posedge pclk);
    read_res(fmt(sacc_pkg::MODE_RIGHT, 10'h31E));
    apb(1'b1, sacc_pkg::OFF_CTRL, 32'h0000_0002);
    wait_done;
    read_res(fmt(sacc_pkg::MODE_RIGHT, 10'h31E));
    repeat (200) @(posedge pclk);
    apb(1'b0, sacc_pkg::OFF_CTRL, 0);
    check("single stops", 32'h0000_0002, rd);
    apb(1'b1, sacc_pkg::OFF_CTRL, 32'h0000_0046);
    for (n = 0; n < 300 && conv_irq !== 1'b1; n++)
      @(posedge pclk);
    if (n == 300)
      give_up("irq raised");
    apb(1'b0, sacc_pkg::OFF_CTRL, 0);
    check("done hidden", 32'h0000_0046, rd);
    read_res(fmt(sacc_pkg::MODE_RIGHT, 10'h31E));
    check("irq cleared", 0, 32'(conv_irq));
    rst_check;
    close_out;
  end
endmodule
`default_nettype wire

// ### core/sacc_pkg.sv
package sacc_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_RES_HI   = 8'h04;
  localparam logic [7:0] OFF_RES_LO   = 8'h08;
  localparam logic [7:0] OFF_CLK      = 8'h0C;
  localparam logic [7:0] OFF_PORT_DAT = 8'h10;
  localparam logic [7:0] OFF_PORT_DIR = 8'h14;

  // Channel select codes
  localparam logic [4:0] CH_PIN_LAST = 5'h07;
  localparam logic [4:0] CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] CH_REF_LOW  = 5'h1E;
  localparam logic [4:0] CH_OFF      = 5'h1F;

  // Result justification modes
  localparam logic [1:0] MODE_LEFT   = 2'h0;
  localparam logic [1:0] MODE_RIGHT  = 2'h1;
  localparam logic [1:0] MODE_SIGNED = 2'h2;
  localparam logic [1:0] MODE_TRUNC  = 2'h3;

  // Prescaler codes and terminal counts
  localparam logic [2:0] DIV_1  = 3'h0;
  localparam logic [2:0] DIV_2  = 3'h1;
  localparam logic [2:0] DIV_4  = 3'h2;
  localparam logic [2:0] DIV_8  = 3'h3;
  localparam logic [3:0] TC_1   = 4'h0;
  localparam logic [3:0] TC_2   = 4'h1;
  localparam logic [3:0] TC_4   = 4'h3;
  localparam logic [3:0] TC_8   = 4'h7;
  localparam logic [3:0] TC_16  = 4'hF;

  // Conversion timing in converter clock ticks
  localparam logic [4:0] TICKS_PER_CONV = 5'h11;
  localparam logic [4:0] FIRST_TRIAL    = 5'h08;
  localparam logic [9:0] SAR_FIRST_CODE = 10'h200;

  // Register field layouts
  typedef struct packed {
    logic       irq_en;
    logic       cont;
    logic [4:0] chan;
  } sacc_ctrl_t;

  typedef struct packed {
    logic [2:0] div;
    logic       in_sel;
    logic [1:0] mode;
  } sacc_clk_t;

  localparam sacc_ctrl_t CTRL_RST = 7'h00;
  localparam sacc_clk_t  CLK_RST  = 6'h00;
  localparam logic [7:0] PORT_RST = 8'h00;

  typedef enum logic {
    SACC_IDLE,
    SACC_CONV
  } sacc_state_t;

endpackage

// ### core/sacc_sar.sv
`timescale 1ns/100ps
`default_nettype none
module sacc_sar (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       trial,
  input  wire logic [3:0] bit_idx,
  input  wire logic       cmp_above,
  output logic      [9:0] code_q,
  output logic      [9:0] res_q,
  output logic            valid_q
);

  // Bit under trial is kept when the input lies above the trial level
  logic [9:0] decided;
  logic [9:0] next_try;

  always_comb
  begin
    decided = code_q;
    decided[bit_idx] = cmp_above;
    next_try = decided;
    if (bit_idx != 4'h0)
    begin
      next_try[bit_idx - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_q  <= 10'h000;
      res_q   <= 10'h000;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= trial && (bit_idx == 4'h0);
      if (trial && (bit_idx == 4'h0))
      begin
        res_q <= decided;
      end
      if (start)
      begin
        code_q <= sacc_pkg::SAR_FIRST_CODE;
      end
      else if (trial)
      begin
        code_q <= next_try;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/sacc_top.sv
// Function
// - Shared pins are input-only under the converter; one of eight channels reaches it.
// - Selected pin leaves port control; unselected pins stay ordinary port pins.
// - Port data and direction writes never change the selected pin.
// - Reading the selected port pin returns zero.
// - High reference converts to full scale, low reference to zero, linear between.
// - Writing the status/control register with any channel code but all ones starts a conversion.
// - A conversion lasts 16 to 17 converter clock cycles.
// - Converter clock is bus or oscillator clock, then prescaled.
// - Start is not aligned to the prescaler; first partial cycle counts seventeenth.
// - Continuous mode overwrites results whether read or not.
// - Continuous conversions repeat until cleared; otherwise one per start.
// - Done flag sets after conversion, holds until control write or result read.
// - Four result formats selected by two justify mode bits.
// - Left mode: eight MSBs high, two LSBs low; read low after high.
// - Right mode: two MSBs high, eight LSBs low.
// - Signed left mode inverts the result MSB.
// - Truncation mode: eight MSBs in low register, no interlock.
// - Enabled interrupt is raised after each completed conversion.
// - With interrupts enabled the done flag reads zero.
// - Converter runs in wait mode; its interrupt can wake the CPU.
// - Conversion is monotonic with no missing codes.
// - Control write aborts any conversion in progress.
// - Codes 0-7 pins, 11101 high ref, 11110 low ref, all ones off.
// - Interrupt clears on result read or control write; reset clears enable.
// - Reading high freezes low until low is read; results meanwhile lost.
`timescale 1ns/100ps
`default_nettype none
module sacc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        oscillator_clock,
  input  wire logic        cmp_above,
  input  wire logic [7:0]  shared_port_pins_in,
  output logic      [7:0]  shared_port_pins_out,
  output logic      [7:0]  shared_port_pins_oe,
  output logic      [7:0]  amux_pin_sel,
  output logic             amux_ref_high,
  output logic             amux_ref_low,
  output logic             adc_power,
  output logic             sample_hold,
  output logic      [9:0]  dac_code,
  output logic             conv_irq
);

  sacc_pkg::sacc_ctrl_t  ctrl_q;
  sacc_pkg::sacc_clk_t   clk_q;
  sacc_pkg::sacc_state_t state_q;
  logic [7:0]  pdat_q;
  logic [7:0]  pdir_q;
  logic [9:0]  res_q;
  logic        done_q;
  logic        irq_q;
  logic        lock_q;
  logic [4:0]  cnt_q;
  logic [3:0]  presc_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0]  pin_s1_q;
  logic [7:0]  pin_s2_q;
  logic        osc_s1_q;
  logic        osc_s2_q;
  logic        osc_s3_q;
  logic        cmp_s1_q;
  logic        cmp_s2_q;
  logic [7:0]  port_out_q;
  logic [7:0]  port_oe_q;
  logic [7:0]  amux_q;
  logic        refh_q;
  logic        refl_q;
  logic        power_q;
  logic        sample_q;
  logic [9:0]  sar_code;
  logic [9:0]  sar_res;
  logic        sar_valid;

  // Bus decode
  wire setup    = psel && !penable;
  wire access   = psel && penable && pready_q;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire hit_ctrl = (paddr == sacc_pkg::OFF_CTRL);
  wire hit_hi   = (paddr == sacc_pkg::OFF_RES_HI);
  wire hit_lo   = (paddr == sacc_pkg::OFF_RES_LO);
  wire hit_clk  = (paddr == sacc_pkg::OFF_CLK);
  wire hit_pdat = (paddr == sacc_pkg::OFF_PORT_DAT);
  wire hit_pdir = (paddr == sacc_pkg::OFF_PORT_DIR);
  wire hit_any  = hit_ctrl || hit_hi || hit_lo || hit_clk || hit_pdat || hit_pdir;
  wire wr_ctrl  = wr && hit_ctrl;
  wire rd_hi    = rd && hit_hi;
  wire rd_lo    = rd && hit_lo;
  wire rd_res   = rd_hi || rd_lo;

  sacc_pkg::sacc_ctrl_t wr_ctrl_val;
  assign wr_ctrl_val = pwdata[6:0];

  // Channel decode
  wire       chan_on  = (ctrl_q.chan != sacc_pkg::CH_OFF);
  wire       chan_pin = (ctrl_q.chan <= sacc_pkg::CH_PIN_LAST);
  wire [7:0] pin_sel  = chan_pin ? (8'h01 << ctrl_q.chan[2:0]) : 8'h00;
  wire       new_on   = (wr_ctrl_val.chan != sacc_pkg::CH_OFF);

  // Converter clock: oscillator edges are seen through a synchroniser
  wire osc_rise = osc_s2_q && !osc_s3_q;
  wire src_tick = clk_q.in_sel ? osc_rise : 1'b1;
  logic [3:0] presc_tc;
  assign presc_tc = (clk_q.div == sacc_pkg::DIV_1) ? sacc_pkg::TC_1 :
                    (clk_q.div == sacc_pkg::DIV_2) ? sacc_pkg::TC_2 :
                    (clk_q.div == sacc_pkg::DIV_4) ? sacc_pkg::TC_4 :
                    (clk_q.div == sacc_pkg::DIV_8) ? sacc_pkg::TC_8 :
                    sacc_pkg::TC_16;
  wire adc_tick = src_tick && (presc_q >= presc_tc);

  // Sequencing
  wire        busy      = (state_q == sacc_pkg::SACC_CONV);
  wire [4:0]  cnt_nx    = cnt_q + 5'h01;
  wire        step      = busy && adc_tick && !wr_ctrl;
  wire        last_tick = step && (cnt_nx == sacc_pkg::TICKS_PER_CONV);
  wire        trial     = step && (cnt_nx >= sacc_pkg::FIRST_TRIAL);
  wire [4:0]  bit_w     = sacc_pkg::TICKS_PER_CONV - cnt_nx;
  wire        restart   = last_tick && ctrl_q.cont && chan_on;
  wire        sar_start = (wr_ctrl && new_on) || restart;
  wire        store     = sar_valid && (!lock_q || clk_q.mode == sacc_pkg::MODE_TRUNC);

  sacc_sar u_sar (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (sar_start),
    .trial     (trial),
    .bit_idx   (bit_w[3:0]),
    .cmp_above (cmp_s2_q),
    .code_q    (sar_code),
    .res_q     (sar_res),
    .valid_q   (sar_valid)
  );

  // Result formatting
  logic [7:0] hi_val;
  logic [7:0] lo_val;
  always_comb
  begin
    case (clk_q.mode)
      sacc_pkg::MODE_LEFT:
      begin
        hi_val = res_q[9:2];
        lo_val = {res_q[1:0], 6'h00};
      end
      sacc_pkg::MODE_RIGHT:
      begin
        hi_val = {6'h00, res_q[9:8]};
        lo_val = res_q[7:0];
      end
      sacc_pkg::MODE_SIGNED:
      begin
        hi_val = {~res_q[9], res_q[8:2]};
        lo_val = {res_q[1:0], 6'h00};
      end
      default:
      begin
        hi_val = 8'h00;
        lo_val = res_q[9:2];
      end
    endcase
  end

  wire [7:0] port_rd = ((pdir_q & pdat_q) | (~pdir_q & pin_s2_q)) & ~pin_sel;
  wire       done_rd = done_q && !ctrl_q.irq_en;
  logic [7:0] rd_val;
  assign rd_val = hit_ctrl ? {done_rd, ctrl_q} :
                  hit_hi   ? hi_val :
                  hit_lo   ? lo_val :
                  hit_clk  ? {clk_q, 2'b00} :
                  hit_pdat ? port_rd :
                  hit_pdir ? pdir_q : 8'h00;

  // Bus slave: zero wait states, answer ready in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_any;
      if (setup)
      begin
        prdata_q <= {24'h00_0000, rd_val};
      end
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= sacc_pkg::CTRL_RST;
      clk_q  <= sacc_pkg::CLK_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= wr_ctrl_val;
      end
      if (wr && hit_clk)
      begin
        clk_q <= pwdata[7:2];
      end
    end
  end

  // Port registers: the converter's pin ignores software writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdat_q <= sacc_pkg::PORT_RST;
      pdir_q <= sacc_pkg::PORT_RST;
    end
    else
    begin
      if (wr && hit_pdat)
      begin
        pdat_q <= (pwdata[7:0] & ~pin_sel) | (pdat_q & pin_sel);
      end
      if (wr && hit_pdir)
      begin
        pdir_q <= (pwdata[7:0] & ~pin_sel) | (pdir_q & pin_sel);
      end
    end
  end

  // Pin and comparator synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= shared_port_pins_in;
      pin_s2_q <= pin_s1_q;
      osc_s1_q <= oscillator_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      cmp_s1_q <= cmp_above;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // Prescaler runs free so a start lands anywhere in a converter cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_q <= 4'h0;
    end
    else if (src_tick)
    begin
      presc_q <= adc_tick ? 4'h0 : presc_q + 4'h1;
    end
  end

  // Conversion sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= sacc_pkg::SACC_IDLE;
      cnt_q   <= 5'h00;
    end
    else
    begin
      case (state_q)
        sacc_pkg::SACC_IDLE:
        begin
          if (wr_ctrl && new_on)
          begin
            state_q <= sacc_pkg::SACC_CONV;
            cnt_q   <= 5'h00;
          end
        end
        sacc_pkg::SACC_CONV:
        begin
          if (wr_ctrl)
          begin
            state_q <= new_on ? sacc_pkg::SACC_CONV : sacc_pkg::SACC_IDLE;
            cnt_q   <= 5'h00;
          end
          else if (last_tick)
          begin
            state_q <= restart ? sacc_pkg::SACC_CONV : sacc_pkg::SACC_IDLE;
            cnt_q   <= 5'h00;
          end
          else if (step)
          begin
            cnt_q <= cnt_nx;
          end
        end
        default:
        begin
          state_q <= sacc_pkg::SACC_IDLE;
          cnt_q   <= 5'h00;
        end
      endcase
    end
  end

  // Result storage and high/low interlock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_q  <= 10'h000;
      lock_q <= 1'b0;
    end
    else
    begin
      if (store)
      begin
        res_q <= sar_res;
      end
      if (rd_hi && clk_q.mode != sacc_pkg::MODE_TRUNC)
      begin
        lock_q <= 1'b1;
      end
      else if (rd_lo)
      begin
        lock_q <= 1'b0;
      end
    end
  end

  // Flag and interrupt: a completion beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      if (sar_valid)
      begin
        done_q <= 1'b1;
      end
      else if (wr_ctrl || rd_res)
      begin
        done_q <= 1'b0;
      end
      if (sar_valid && ctrl_q.irq_en)
      begin
        irq_q <= 1'b1;
      end
      else if (wr_ctrl || rd_res || !ctrl_q.irq_en)
      begin
        irq_q <= 1'b0;
      end
    end
  end

  // Registered pin and analog-side outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_out_q <= 8'h00;
      port_oe_q  <= 8'h00;
      amux_q     <= 8'h00;
      refh_q     <= 1'b0;
      refl_q     <= 1'b0;
      power_q    <= 1'b0;
      sample_q   <= 1'b0;
    end
    else
    begin
      port_out_q <= pdat_q & ~pin_sel;
      port_oe_q  <= pdir_q & ~pin_sel;
      amux_q     <= pin_sel;
      refh_q     <= (ctrl_q.chan == sacc_pkg::CH_REF_HIGH);
      refl_q     <= (ctrl_q.chan == sacc_pkg::CH_REF_LOW);
      power_q    <= chan_on;
      sample_q   <= busy && (cnt_q < sacc_pkg::FIRST_TRIAL - 5'h01);
    end
  end

  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign shared_port_pins_out = port_out_q;
  assign shared_port_pins_oe  = port_oe_q;
  assign amux_pin_sel         = amux_q;
  assign amux_ref_high        = refh_q;
  assign amux_ref_low         = refl_q;
  assign adc_power            = power_q;
  assign sample_hold          = sample_q;
  assign dac_code             = sar_code;
  assign conv_irq             = irq_q;

endmodule
`default_nettype wire
